// ==== rtl/adc_ctrl_pkg.sv ====
// Constants and types shared by the converter control front end.
// Assumes a single 50 MHz system clock; the serial clock is sampled.
package adc_ctrl_pkg;

    // =========================================================
    // Register file geometry
    localparam int REG_COUNT = 16;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int RANGE_W = 15;

    // =========================================================
    // Serial frame layout
    localparam logic [4:0] FRAME_BITS = 5'h18;
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] LAST_DATA_IDX = 5'h17;
    localparam int SHIFT_W = 24;
    localparam int WR_ADDR_LSB = 16;
    localparam int RD_ADDR_LSB = 1;

    // =========================================================
    // Register addresses, field positions and values after load
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_I_RANGE = 4'h3;
    localparam logic [3:0] ADDR_Q_RANGE = 4'hB;
    localparam int BIT_Q_DOWN = 10;
    localparam int BIT_I_DOWN = 11;
    localparam int BIT_PATTERN = 12;
    localparam logic [15:0] IMPL_MASK = 16'h7C0F;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [15:0] CTRL_DEFAULT = 16'h2000;
    localparam logic [15:0] RANGE_DEFAULT = 16'h4000;
    localparam logic [15:0] OTHER_DEFAULT = 16'h0000;
    localparam logic [14:0] RANGE_LOW_CODE = 15'h2000;
    localparam logic [14:0] RANGE_HIGH_CODE = 15'h6000;

    // =========================================================
    // Pin vector positions and widths
    localparam int PIN_W = 9;
    localparam int PIN_SEL = 0;
    localparam int PIN_Q_DOWN = 1;
    localparam int PIN_I_DOWN = 2;
    localparam int PIN_PATTERN = 3;
    localparam int PIN_RANGE = 4;
    localparam int PIN_CMS = 5;
    localparam int PIN_CSN = 6;
    localparam int PIN_SCK = 7;
    localparam int PIN_DIN = 8;
    localparam int PATTERN_LANES = 6;

    typedef enum logic [1:0] {SER_IDLE, SER_SHIFT, SER_HOLD} ser_state_t;

    // Value a register takes while pin control is selected
    function automatic logic [15:0] default_of(input logic [3:0] addr);
        logic [15:0] val;
        val = OTHER_DEFAULT;
        if (addr == ADDR_CTRL) begin
            val = CTRL_DEFAULT;
        end else if (addr == ADDR_I_RANGE || addr == ADDR_Q_RANGE) begin
            val = RANGE_DEFAULT;
        end
        return val;
    endfunction

endpackage

// ==== rtl/regs_if.sv ====
// Carrier between the serial engine and the register store.
// Assumes both ends run on the same system clock.
`timescale 1ns/100ps
`default_nettype none
interface regs_if;
    import adc_ctrl_pkg::*;
    logic load_defaults;
    logic wr_en;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic [DATA_W-1:0] ctrl_word;
    logic [RANGE_W-1:0] i_range;
    logic [RANGE_W-1:0] q_range;

    modport engine (output load_defaults, wr_en, wr_addr, wr_data, rd_addr,
        input rd_data, ctrl_word, i_range, q_range);
    modport store (input load_defaults, wr_en, wr_addr, wr_data, rd_addr,
        output rd_data, ctrl_word, i_range, q_range);
endinterface
`default_nettype wire

// ==== rtl/reg_store.sv ====
// Sixteen 16-bit control registers held in flip-flops.
// Assumes writes arrive as one-cycle strobes on the system clock.
`timescale 1ns/100ps
`default_nettype none
module reg_store
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Register access
    regs_if.store rf
);

    logic [DATA_W-1:0] regs_ff [REG_COUNT];
    logic [DATA_W-1:0] nxt_regs [REG_COUNT];

    // =========================================================
    // Next register contents
    // defaults while pin control
    always_comb begin
        for (int k = 0; k < REG_COUNT; k++) begin
            nxt_regs[k] = regs_ff[k];
            if (rf.load_defaults) begin
                nxt_regs[k] = default_of(ADDR_W'(k));
            end else if (rf.wr_en && rf.wr_addr == ADDR_W'(k) && IMPL_MASK[k]) begin
                nxt_regs[k] = rf.wr_data;
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int k = 0; k < REG_COUNT; k++) begin
                regs_ff[k] <= REG_RESET;
            end
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // =========================================================
    // Read port and steering fields
    // unimplemented reads zero
    assign rf.rd_data = IMPL_MASK[rf.rd_addr] ? regs_ff[rf.rd_addr] : '0;
    assign rf.ctrl_word = regs_ff[ADDR_CTRL];
    assign rf.i_range = regs_ff[ADDR_I_RANGE][RANGE_W-1:0];
    assign rf.q_range = regs_ff[ADDR_Q_RANGE][RANGE_W-1:0];

endmodule
`default_nettype wire

// ==== rtl/adc_serial_control_port.sv ====
// Control front end: static pin decode plus 24-bit serial register port.
// Assumes all pins are asynchronous to mclk_in and the serial clock is
// far slower than mclk_in, so its edges are found by sampling.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_control_port
    import adc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic mclk_in,
    input wire logic rst_in,
    // Static control pins; select high means pin control
    input wire logic pin_control_select_n_in,
    input wire logic q_chan_powerdown_in,
    input wire logic i_chan_powerdown_in,
    input wire logic test_pattern_select_in,
    input wire logic range_select_in,
    input wire logic common_mode_select_in,
    // Serial port
    input wire logic serial_select_n_in,
    input wire logic serial_clk_in,
    input wire logic serial_in_in,
    output logic serial_out_out,
    output logic serial_out_oe_out,
    // Decoded controls
    output logic extended_control_out,
    output logic q_powered_down_out,
    output logic i_powered_down_out,
    output logic test_pattern_out,
    output logic [PATTERN_LANES-1:0] pattern_route_out,
    output logic [RANGE_W-1:0] i_range_out,
    output logic [RANGE_W-1:0] q_range_out,
    output logic common_mode_high_out
);

    regs_if rf ();

    // =========================================================
    // Pin synchronisers
    logic [PIN_W-1:0] pins_raw;
    logic [PIN_W-1:0] meta_ff;
    logic [PIN_W-1:0] sync_ff;
    logic sclk_prev_ff;

    assign pins_raw[PIN_SEL] = pin_control_select_n_in;
    assign pins_raw[PIN_Q_DOWN] = q_chan_powerdown_in;
    assign pins_raw[PIN_I_DOWN] = i_chan_powerdown_in;
    assign pins_raw[PIN_PATTERN] = test_pattern_select_in;
    assign pins_raw[PIN_RANGE] = range_select_in;
    assign pins_raw[PIN_CMS] = common_mode_select_in;
    assign pins_raw[PIN_CSN] = serial_select_n_in;
    assign pins_raw[PIN_SCK] = serial_clk_in;
    assign pins_raw[PIN_DIN] = serial_in_in;

    // Two stages; only the second stage is read
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_ff <= '0;
            sync_ff <= '0;
            sclk_prev_ff <= 1'b0;
        end else begin
            meta_ff <= pins_raw;
            sync_ff <= meta_ff;
            sclk_prev_ff <= sync_ff[PIN_SCK];
        end
    end

    logic pin_ctrl;
    logic cs_high;
    logic din_s;
    logic sck_rise;
    logic sck_fall;

    // Synchronised views and serial clock edges
    assign pin_ctrl = sync_ff[PIN_SEL];
    assign cs_high = sync_ff[PIN_CSN];
    assign din_s = sync_ff[PIN_DIN];
    assign sck_rise = sync_ff[PIN_SCK] & ~sclk_prev_ff;
    assign sck_fall = ~sync_ff[PIN_SCK] & sclk_prev_ff;

    // =========================================================
    // Serial engine
    ser_state_t state_ff;
    ser_state_t nxt_state;
    logic [4:0] cnt_ff;
    logic [4:0] nxt_cnt;
    logic [SHIFT_W-1:0] sh_ff;
    logic [SHIFT_W-1:0] nxt_sh;
    logic [DATA_W-1:0] rdw_ff;
    logic [DATA_W-1:0] nxt_rdw;
    logic rw_ff;
    logic nxt_rw;
    logic dout_ff;
    logic nxt_dout;
    logic oe_ff;
    logic nxt_oe;
    logic wr_en;

    // Next state of the serial engine
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_sh = sh_ff;
        nxt_rdw = rdw_ff;
        nxt_rw = rw_ff;
        nxt_dout = dout_ff;
        nxt_oe = oe_ff;
        wr_en = 1'b0;
        if (pin_ctrl || cs_high) begin
            nxt_state = SER_IDLE;
            nxt_cnt = '0;
            nxt_sh = '0;
            nxt_rw = 1'b0;
            nxt_dout = 1'b0;
            nxt_oe = 1'b0;
        end else begin
            unique case (state_ff)
                SER_IDLE: begin
                    nxt_state = SER_SHIFT;
                end
                SER_SHIFT: begin
                    if (sck_rise) begin
                        nxt_sh = {sh_ff[SHIFT_W-2:0], din_s};
                        nxt_cnt = cnt_ff + 5'h01;
                        if (cnt_ff == '0) begin
                            nxt_rw = din_s;
                        end
                        if (cnt_ff == FRAME_BITS - 5'h01) begin
                            nxt_state = SER_HOLD;
                            wr_en = ~rw_ff;
                        end
                    end
                    if (sck_fall && rw_ff && cnt_ff >= CMD_BITS) begin
                        nxt_oe = 1'b1;
                        if (cnt_ff == CMD_BITS) begin
                            nxt_rdw = rf.rd_data;
                            nxt_dout = rf.rd_data[DATA_W-1];
                        end else begin
                            nxt_dout = rdw_ff[4'(LAST_DATA_IDX - cnt_ff)];
                        end
                    end
                end
                // extra clocks ignored, last bit held
                SER_HOLD: begin
                    nxt_state = SER_HOLD;
                end
            endcase
        end
    end

    // Serial engine registers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_ff <= SER_IDLE;
            cnt_ff <= '0;
            sh_ff <= '0;
            rdw_ff <= '0;
            rw_ff <= 1'b0;
            dout_ff <= 1'b0;
            oe_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            sh_ff <= nxt_sh;
            rdw_ff <= nxt_rdw;
            rw_ff <= nxt_rw;
            dout_ff <= nxt_dout;
            oe_ff <= nxt_oe;
        end
    end

    // address and data fields of the frame
    assign rf.wr_en = wr_en;
    assign rf.wr_addr = sh_ff[WR_ADDR_LSB +: ADDR_W];
    assign rf.wr_data = {sh_ff[DATA_W-2:0], din_s};
    assign rf.rd_addr = sh_ff[RD_ADDR_LSB +: ADDR_W];
    assign rf.load_defaults = pin_ctrl;
    assign serial_out_out = dout_ff;
    assign serial_out_oe_out = oe_ff;

    reg_store u_store (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .rf(rf)
    );

    // =========================================================
    // Control decode
    logic ext_mode;
    logic tp;
    logic ext_ff;
    logic qpd_ff;
    logic ipd_ff;
    logic tp_ff;
    logic cm_ff;
    logic [PATTERN_LANES-1:0] route_ff;
    logic [RANGE_W-1:0] irange_ff;
    logic [RANGE_W-1:0] qrange_ff;
    logic nxt_ext;
    logic nxt_qpd;
    logic nxt_ipd;
    logic nxt_tp;
    logic nxt_cm;
    logic [PATTERN_LANES-1:0] nxt_route;
    logic [RANGE_W-1:0] nxt_irange;
    logic [RANGE_W-1:0] nxt_qrange;

    // Next values of the decoded controls
    always_comb begin
        ext_mode = ~pin_ctrl;
        nxt_ext = ext_mode;
        // extended mode ORs in bit 10
        nxt_qpd = sync_ff[PIN_Q_DOWN] | (ext_mode & rf.ctrl_word[BIT_Q_DOWN]);
        // I follows only its own controls
        nxt_ipd = sync_ff[PIN_I_DOWN] | (ext_mode & rf.ctrl_word[BIT_I_DOWN]);
        tp = ext_mode ? rf.ctrl_word[BIT_PATTERN] : sync_ff[PIN_PATTERN];
        nxt_tp = tp;
        nxt_route = {PATTERN_LANES{tp}};
        if (ext_mode) begin
            nxt_irange = rf.i_range;
            nxt_qrange = rf.q_range;
        end else begin
            nxt_irange = sync_ff[PIN_RANGE] ? RANGE_HIGH_CODE : RANGE_LOW_CODE;
            nxt_qrange = nxt_irange;
        end
        nxt_cm = sync_ff[PIN_CMS];
    end

    // Decoded control registers
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_ff <= 1'b0;
            qpd_ff <= 1'b0;
            ipd_ff <= 1'b0;
            tp_ff <= 1'b0;
            cm_ff <= 1'b0;
            route_ff <= '0;
            irange_ff <= RANGE_LOW_CODE;
            qrange_ff <= RANGE_LOW_CODE;
        end else begin
            ext_ff <= nxt_ext;
            qpd_ff <= nxt_qpd;
            ipd_ff <= nxt_ipd;
            tp_ff <= nxt_tp;
            cm_ff <= nxt_cm;
            route_ff <= nxt_route;
            irange_ff <= nxt_irange;
            qrange_ff <= nxt_qrange;
        end
    end

    assign extended_control_out = ext_ff;
    assign q_powered_down_out = qpd_ff;
    assign i_powered_down_out = ipd_ff;
    assign test_pattern_out = tp_ff;
    assign pattern_route_out = route_ff;
    assign i_range_out = irange_ff;
    assign q_range_out = qrange_ff;
    assign common_mode_high_out = cm_ff;

    // =========================================================
    // Assertions
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    wr_at_24_a: assert property (rf.wr_en |-> cnt_ff == 5'h17 && sck_rise && !rw_ff)
        else $error("write outside the 24th bit");
    early_release_a: assert property (cs_high && !pin_ctrl |=> $stable(rf.ctrl_word) && $stable(rf.i_range))
        else $error("register changed without a whole access");
    q_power_a: assert property (sync_ff[PIN_Q_DOWN] || (!pin_ctrl && rf.ctrl_word[BIT_Q_DOWN])
        |=> q_powered_down_out)
        else $error("Q channel not powered down");
    i_indep_a: assert property (!sync_ff[PIN_I_DOWN] && (pin_ctrl || !rf.ctrl_word[BIT_I_DOWN])
        |=> !i_powered_down_out)
        else $error("I channel down without its own request");
    oe_start_a: assert property ($rose(serial_out_oe_out) |-> $past(cnt_ff) == 5'h08 && rw_ff)
        else $error("output enabled outside read data phase");
    release_clear_a: assert property (cs_high |=> cnt_ff == '0 && !serial_out_oe_out)
        else $error("select release did not clear the access");
    hold_last_a: assert property (state_ff == SER_HOLD && !cs_high && !pin_ctrl
        |=> $stable(serial_out_out) && cnt_ff == 5'h18)
        else $error("last data bit not held");
    pin_defaults_a: assert property (pin_ctrl [*2] |-> rf.ctrl_word == CTRL_DEFAULT)
        else $error("defaults not loaded in pin mode");
    pin_range_a: assert property (pin_ctrl && sync_ff[PIN_RANGE]
        |=> i_range_out == RANGE_HIGH_CODE && q_range_out == RANGE_HIGH_CODE)
        else $error("range pin not applied to both channels");
    pattern_all_a: assert property (pin_ctrl && sync_ff[PIN_PATTERN] |=> &pattern_route_out)
        else $error("pattern not routed to every lane");
    cm_level_a: assert property (sync_ff[PIN_CMS] |=> common_mode_high_out)
        else $error("common-mode select not followed");

    write_cov: cover property (rf.wr_en);
    read_cov: cover property ($rose(serial_out_oe_out) ##[1:300] $fell(serial_out_oe_out));
    abort_cov: cover property ($rose(cs_high) && cnt_ff > '0 && cnt_ff < 5'h18);
    hold_cov: cover property (state_ff == SER_HOLD && sck_rise);

endmodule
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host serial master model that drives frames into the control port.
// Assumes the bench clock on mclk_in; one serial period is eight of its cycles.
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // Bench clock
    input wire logic mclk_in,
    // Lines from the device
    input wire logic dev_data_in,
    input wire logic dev_oe_in,
    // Lines to the device
    output logic select_n_out,
    output logic sclk_out,
    output logic data_out
);
    // ==========================================================
    // Idle levels
    // serial clock stands low outside frames
    initial begin
        select_n_out = 1'b1;
        sclk_out = 1'b0;
        data_out = 1'b0;
    end

    // ==========================================================
    // One frame of nbits clocks, device sampled mid high phase
    task automatic xfer(input logic [23:0] word, input int nbits, input logic drive_exp, input int stall,
            output logic [15:0] rdata, output logic last_bit, output int oe_bad);
        logic rd;
        rd = word[23];
        rdata = 16'h0000;
        last_bit = 1'b0;
        oe_bad = 0;
        // select low opens a fresh access
        @(posedge mclk_in);
        select_n_out <= 1'b0;
        repeat (4) @(posedge mclk_in);
        // count of clocks set by the caller, 24 for a whole access
        for (int i = 1; i <= nbits; i++) begin
            // command MSB first, read data field driven with toggling bits
            if (i <= 24 && !(rd && i > 8)) data_out <= word[24 - i];
            else data_out <= ~data_out;
            repeat (4) @(posedge mclk_in);
            // rise samples input, output launched on prior fall
            sclk_out <= 1'b1;
            repeat (2) @(negedge mclk_in);
            if (dev_oe_in !== (drive_exp && i > 8)) oe_bad++;
            if (i > 8 && i <= 24) rdata[24 - i] = dev_data_in;
            last_bit = dev_data_in;
            repeat (3) @(posedge mclk_in);
            sclk_out <= 1'b0;
            if (i == 12) repeat (stall) @(posedge mclk_in);
        end
        repeat (4) @(posedge mclk_in);
        select_n_out <= 1'b1;
        data_out <= ~data_out;
        repeat (4) @(posedge mclk_in);
    endtask
endmodule
`default_nettype wire

// ==== testbench/adc_serial_control_port_bench.sv ====
// Self-checking bench for the converter control front end.
// Assumes the host model drives the serial pins; the bench drives static pins.
`timescale 1ns/100ps
`default_nettype none
module adc_serial_control_port_bench;
    import adc_ctrl_pkg::*;
    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic pin_sel = 1'b1;
    logic q_down = 1'b0;
    logic i_down = 1'b0;
    logic pattern_sel = 1'b0;
    logic range_sel = 1'b0;
    logic cms = 1'b0;
    wire logic sel_n;
    wire logic sclk;
    wire logic din;
    logic dout, dout_oe, ext_o, qpd_o, ipd_o, tp_o, cm_o;
    logic [PATTERN_LANES-1:0] route_o;
    logic [RANGE_W-1:0] ir_o, qr_o;
    logic [15:0] exp_reg [16];
    int n_errors = 0;
    int num_checks = 0;
    int seed;

    // ==========================================================
    // Clock and instances
    always #10 mclk_in = ~mclk_in;

    adc_serial_control_port i_dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .pin_control_select_n_in(pin_sel), .q_chan_powerdown_in(q_down), .i_chan_powerdown_in(i_down),
        .test_pattern_select_in(pattern_sel), .range_select_in(range_sel), .common_mode_select_in(cms),
        .serial_select_n_in(sel_n), .serial_clk_in(sclk), .serial_in_in(din),
        .serial_out_out(dout), .serial_out_oe_out(dout_oe), .extended_control_out(ext_o),
        .q_powered_down_out(qpd_o), .i_powered_down_out(ipd_o), .test_pattern_out(tp_o),
        .pattern_route_out(route_o), .i_range_out(ir_o), .q_range_out(qr_o),
        .common_mode_high_out(cm_o));

    host_model i_host (.mclk_in(mclk_in), .dev_data_in(dout), .dev_oe_in(dout_oe),
        .select_n_out(sel_n), .sclk_out(sclk), .data_out(din));

    // ==========================================================
    // Expectations and checks
    function automatic logic [40:0] exp_dec();
        logic ext;
        logic tp;
        logic [15:0] c;
        ext = !pin_sel;
        c = exp_reg[ADDR_CTRL];
        tp = ext ? c[BIT_PATTERN] : pattern_sel;
        return {ext, q_down | (ext & c[BIT_Q_DOWN]), i_down | (ext & c[BIT_I_DOWN]),
            tp, {PATTERN_LANES{tp}}, cms,
            ext ? exp_reg[ADDR_I_RANGE][14:0] : (range_sel ? RANGE_HIGH_CODE : RANGE_LOW_CODE),
            ext ? exp_reg[ADDR_Q_RANGE][14:0] : (range_sel ? RANGE_HIGH_CODE : RANGE_LOW_CODE)};
    endfunction

    task automatic check(input logic [40:0] got, input logic [40:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask

    task automatic check_dec();
        @(negedge mclk_in);
        check({ext_o, qpd_o, ipd_o, tp_o, route_o, cm_o, ir_o, qr_o}, exp_dec());
    endtask

    // Randomise static pins; pin control reloads the defaults
    task automatic set_pins(input logic sel);
        @(posedge mclk_in);
        pin_sel <= sel;
        q_down <= 1'($urandom);
        i_down <= 1'($urandom);
        pattern_sel <= 1'($urandom);
        range_sel <= 1'($urandom);
        cms <= 1'($urandom);
        repeat (6) @(posedge mclk_in);
        // defaults loaded while pin control is selected
        if (sel) begin
            foreach (exp_reg[a]) exp_reg[a] = (a == 0) ? CTRL_DEFAULT : (a == 3 || a == 11) ? RANGE_DEFAULT
                : OTHER_DEFAULT;
        end
    endtask

    // One serial access with its expected outcome
    task automatic access(input logic rw, input logic [3:0] addr, input logic [15:0] data, input int nbits);
        logic [15:0] rdata;
        logic [15:0] expd;
        logic last;
        logic ext;
        int oe_bad;
        int stall;
        ext = !pin_sel;
        stall = 20 * int'($urandom % 3);
        expd = IMPL_MASK[addr] ? exp_reg[addr] : 16'h0000;
        // read flag, fixed pair, address, spare, data
        i_host.xfer({rw, 2'b10, addr, 1'b0, data}, nbits, rw && ext, stall, rdata, last, oe_bad);
        check(41'(oe_bad), 41'h0);
        if (!rw && ext && nbits >= 24 && IMPL_MASK[addr]) exp_reg[addr] = data;
        if (rw && ext && nbits >= 24) check(41'(rdata), 41'(expd));
        if (rw && ext && nbits > 24) check(41'(last), 41'(expd[0]));
        @(negedge mclk_in);
        check(41'(dout_oe), 41'h0);
        check_dec();
    endtask

    // ==========================================================
    // Test sequence
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog against a hung run
    initial begin
        repeat (50000) @(posedge mclk_in);
        n_errors++;
        conclude();
    end

    // Main stimulus
    initial begin
        seed = $urandom(2);
        repeat (2) @(negedge mclk_in);
        check({ext_o, qpd_o, ipd_o, tp_o, route_o, cm_o, ir_o, qr_o}, {11'h000, RANGE_LOW_CODE,
            RANGE_LOW_CODE});
        repeat (2) @(posedge mclk_in);
        rst_in <= 1'b0;
        for (int k = 0; k < 10; k++) begin
            set_pins(1'b1);
            check_dec();
        end
        $display("test pin decode done");
        set_pins(1'b0);
        for (int a = 0; a < 16; a++) access(1'b1, 4'(a), 16'h0000, 24);
        $display("test defaults done");
        for (int k = 0; k < 24; k++) begin
            // host calibration after range writes lies outside this port
            access(1'b0, 4'($urandom), 16'($urandom), 24);
            access(1'b1, 4'($urandom), 16'h0000, 24);
            if (k % 6 == 0) set_pins(1'b0);
        end
        // explicit default writes over the serial port
        access(1'b0, ADDR_CTRL, CTRL_DEFAULT, 24);
        access(1'b1, ADDR_CTRL, 16'h0000, 24);
        $display("test random access done");
        access(1'b0, ADDR_I_RANGE, 16'h1234, 23);
        access(1'b0, ADDR_CTRL, 16'h1C00, 8);
        access(1'b1, ADDR_I_RANGE, 16'h0000, 12);
        access(1'b1, ADDR_I_RANGE, 16'h0000, 24);
        $display("test early release done");
        access(1'b0, ADDR_Q_RANGE, 16'h5A5B, 28);
        access(1'b1, ADDR_Q_RANGE, 16'h0000, 28);
        access(1'b0, ADDR_Q_RANGE, 16'h7FFE, 30);
        access(1'b1, ADDR_Q_RANGE, 16'h0000, 30);
        $display("test long select done");
        set_pins(1'b1);
        access(1'b0, ADDR_CTRL, 16'h1C00, 24);
        access(1'b1, ADDR_CTRL, 16'h0000, 24);
        set_pins(1'b0);
        access(1'b1, ADDR_CTRL, 16'h0000, 24);
        $display("test pin control ignore done");
        conclude();
    end
endmodule
`default_nettype wire
